// [core/ccc_pkg.sv]
// constants and types shared by the colour controller command registers
package ccc_pkg;

	// ==========================================================
	// register addresses
	localparam logic [7:0] A_CTRL      = 8'h01;
	localparam logic [7:0] A_CFG       = 8'h03;
	localparam logic [7:0] A_BRL       = 8'h19;
	localparam logic [7:0] A_BRH       = 8'h1a;
	localparam logic [7:0] A_XL        = 8'h1b;
	localparam logic [7:0] A_XH        = 8'h1c;
	localparam logic [7:0] A_YL        = 8'h1d;
	localparam logic [7:0] A_YH        = 8'h1e;
	localparam logic [7:0] A_LL        = 8'h1f;
	localparam logic [7:0] A_LH        = 8'h20;
	localparam logic [7:0] A_STAT      = 8'h22;
	localparam logic [7:0] A_ERR       = 8'h23;
	localparam logic [7:0] A_DUTY0     = 8'h24;
	localparam logic [7:0] A_DUTY_LAST = 8'h29;
	localparam logic [7:0] A_XFER_BASE = 8'h40;

	// ==========================================================
	// bit positions
	localparam int B_SRST  = 0;
	localparam int B_UPD   = 1;
	localparam int B_UPCP  = 2;
	localparam int B_DLALL = 3;
	localparam int B_UPALL = 4;
	localparam int B_DLCAL = 5;
	localparam int B_PWM_ENABLE_BIT  = 0;
	localparam int B_POL   = 1;
	localparam int B_AUTO  = 2;
	localparam int B_INIT  = 0;
	localparam int B_RANGE = 0;
	localparam int B_NO_LOCK_FLAG = 1;
	localparam int B_EEPROM_NO_ACK_FLAG  = 5;
	localparam int B_BAD_ACQUISITION_CONSTANT_FLAG  = 7;

	// ==========================================================
	// reset values and sizes
	localparam logic [7:0]  RST_CTRL   = 8'h00;
	localparam logic [7:0]  RST_CFG    = 8'h00;
	localparam logic [11:0] RST_BRIGHT = 12'h0e79;
	localparam logic [11:0] RST_DUTY   = 12'h000;
	localparam logic [6:0]  N_CAL      = 7'h33;
	localparam logic [6:0]  N_ALL      = 7'h47;
	localparam logic [6:0]  N_CP       = 7'h08;
	localparam logic [6:0]  CP_FIRST   = 7'h3f;
	localparam logic [10:0] CHROMA_MAX = 11'h3e8;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int BOOT_TIME_NS  = 2000;
	localparam int BOOT_CYCLES   =
		(BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// types
	typedef struct packed {
		logic [11:0] bright;
		logic [9:0]  x;
		logic [9:0]  y;
		logic [15:0] lum;
	} ccc_setpoint_t;

	typedef enum logic [2:0] {
		ST_BOOT  = 3'h0,
		ST_PROBE = 3'h1,
		ST_IDLE  = 3'h2,
		ST_XFER  = 3'h3,
		ST_APPLY = 3'h4
	} ccc_state_t;

endpackage : ccc_pkg

// [core/ccc_regs.sv]
// host register bank and eeprom sequencer of the colour controller
// ==========================================================
// Summary of operation
// - writing 01H to primary control runs a soft reset like power-on
// - initialising flag stays high through the reset sequence, then clears
// - reset clears all duty registers and the pwm enable bit
// - polarity bit clear gives active-high pwm, set gives active-low
// - calibration download fetches 51 bytes starting with configuration
// - brightness target held as high byte 1AH and low byte 19H
// - brightness target defaults to 0E79H, full brightness
// - chroma coordinate times 1000: upper 2 bits high, 8 bits low
// - writing 02H applies new set point, bit clears when done
// - pwm enable bit starts the pwm generator driving the leds
// - bad acquisition constant sets error bit 7 until recalibration
// - error bit 1 reads one while pwm is enabled and the set point is not reached
// - out-of-range set point sets error bit 0, previous point kept
// - upload-all writes 71 bytes to eeprom, bit clears when finished
// - eeprom no-acknowledge sets error bit 5 for host to read
// - stored auto-load bit reloads data after every reset, shows colour
// - colour-point upload saves only set point data, then clears
// - stored auto-load cleared means no auto-load at next power-up
// - wide registers: low byte in low register, rest in high register
`timescale 1ns/1ps
module ccc_regs
	import ccc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	output logic      [7:0]    reg_rdata,
	output logic               ee_req,
	output logic               ee_we,
	output logic      [7:0]    ee_addr,
	output logic      [7:0]    ee_wdata,
	input  wire logic          ee_done,
	input  wire logic          ee_eeprom_no_ack_flag,
	input  wire logic [7:0]    ee_rdata,
	output logic               ext_we,
	output logic      [7:0]    ext_addr,
	output logic      [7:0]    ext_wdata,
	input  wire logic [7:0]    ext_rdata,
	input  wire logic          acq_fault,
	input  wire logic          cal_restart,
	input  wire logic          loop_locked,
	input  wire logic          open_loop,
	input  wire logic [2:0]    pwm_raw,
	output logic      [2:0]    led_pwm,
	output logic               pwm_enable,
	output ccc_setpoint_t      setpoint,
	output logic      [11:0]   duty_blue,
	output logic      [11:0]   duty_green,
	output logic      [11:0]   duty_red
);

	// ==========================================================
	// storage
	ccc_state_t  state;
	logic        soft_rst;
	logic        rst_all;
	logic [7:0]  ctrl;
	logic [7:0]  cfg;
	logic [11:0] bright;
	logic [9:0]  cx;
	logic [9:0]  cy;
	logic [15:0] lum;
	logic [11:0] duty [0:2];
	logic        range_f;
	logic        eeprom_no_ack_flag_f;
	logic        bad_acquisition_constant_flag_f;
	logic [7:0]  boot_cnt;
	logic [6:0]  idx;
	logic [6:0]  last;
	logic        dir_rd;
	logic        boot_load;
	logic [2:0]  cmd_bit;
	logic        init_flag;
	logic        no_lock_flag;
	logic        xfer_on;
	logic        xfer_wr;
	logic        host_w;
	logic        w_en;
	logic [7:0]  w_addr;
	logic [7:0]  w_data;
	logic [7:0]  map_addr;
	logic        byte_ok;
	logic        xfer_end;
	logic        cmd_clear;
	logic        pt_ok;
	logic [10:0] xy_sum;

	// ==========================================================
	// helpers
	function automatic logic [7:0] idx_to_addr(input logic [6:0] i);
		logic [2:0] k;
		k = 3'(i - CP_FIRST);
		if (i == 7'h00) begin
			return A_CFG;
		end else if (i >= CP_FIRST) begin
			case (k)
				3'h0: return A_BRL;
				3'h1: return A_BRH;
				3'h2: return A_XL;
				3'h3: return A_XH;
				3'h4: return A_YL;
				3'h5: return A_YH;
				3'h6: return A_LL;
				default: return A_LH;
			endcase
		end else begin
			return 8'(A_XFER_BASE + {1'b0, i} - 8'h01);
		end
	endfunction : idx_to_addr

	// reads outside the local map come from the shared table storage
	function automatic logic [7:0] local_rd(input logic [7:0] a,
		input logic [7:0] ext);
		logic [1:0] d;
		d = 2'((a - A_DUTY0) >> 1);
		if (a >= A_DUTY0 && a <= A_DUTY_LAST) begin
			return a[0] ? {4'h0, duty[d][11:8]} : duty[d][7:0];
		end
		case (a)
			A_CTRL: return ctrl;
			A_CFG:  return cfg;
			A_BRL:  return bright[7:0];
			A_BRH:  return {4'h0, bright[11:8]};
			A_XL:   return cx[7:0];
			A_XH:   return {6'h00, cx[9:8]};
			A_YL:   return cy[7:0];
			A_YH:   return {6'h00, cy[9:8]};
			A_LL:   return lum[7:0];
			A_LH:   return lum[15:8];
			A_STAT: return {5'h00, open_loop, ~open_loop, init_flag};
			A_ERR:  return {bad_acquisition_constant_flag_f, 1'b0, eeprom_no_ack_flag_f, 3'h0, no_lock_flag, range_f};
			default: return ext;
		endcase
	endfunction : local_rd

	function automatic logic is_local(input logic [7:0] a);
		return (a >= A_DUTY0 && a <= A_DUTY_LAST) || a == A_CTRL ||
			a == A_CFG || (a >= A_BRL && a <= A_LH) ||
			a == A_STAT || a == A_ERR;
	endfunction : is_local

	// ==========================================================
	// soft reset: one cycle pulse that resets everything else
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= host_w && reg_addr == A_CTRL &&
				reg_wdata[B_SRST] && !soft_rst;
		end
	end
	assign rst_all = !rst_n || soft_rst;

	// ==========================================================
	// write path shared by host and eeprom download
	assign xfer_on   = state == ST_XFER;
	assign map_addr  = idx_to_addr(idx);
	assign byte_ok   = ee_done && !ee_eeprom_no_ack_flag;
	assign xfer_end  = xfer_on && ee_done && (ee_eeprom_no_ack_flag || idx == last);
	assign xfer_wr   = byte_ok && dir_rd && (xfer_on ||
		(state == ST_PROBE && ee_rdata[B_AUTO]));
	// host writes are held off while a transfer owns the write path
	assign host_w    = reg_wr && !xfer_on;
	assign w_en      = xfer_wr || host_w;
	assign w_addr    = xfer_wr ? map_addr : reg_addr;
	assign w_data    = xfer_wr ? ee_rdata : reg_wdata;
	assign ext_we    = w_en && !is_local(w_addr);
	assign ext_addr  = xfer_on ? map_addr : reg_addr;
	assign ext_wdata = w_data;
	assign ee_we     = !dir_rd;
	assign ee_addr   = {1'b0, idx};
	// always_comb so the register reads inside the function keep it current
	always_comb begin
		ee_wdata = local_rd(map_addr, ext_rdata);
	end
	assign init_flag = state == ST_BOOT || state == ST_PROBE || boot_load;
	assign no_lock_flag     = cfg[B_PWM_ENABLE_BIT] && !loop_locked;
	assign cmd_clear = (xfer_end && !boot_load) ||
		(state == ST_APPLY && !boot_load);
	assign xy_sum    = {1'b0, cx} + {1'b0, cy};
	assign pt_ok     = cx != 10'h000 && cy != 10'h000 &&
		xy_sum <= CHROMA_MAX;

	// ==========================================================
	// data registers
	always_ff @(posedge clk) begin
		if (rst_all) begin
			cfg    <= RST_CFG;
			bright <= RST_BRIGHT;
			cx     <= 10'h000;
			cy     <= 10'h000;
			lum    <= 16'h0000;
			for (int i = 0; i < 3; i++) begin
				duty[i] <= RST_DUTY;
			end
		end else if (w_en) begin
			if (w_addr >= A_DUTY0 && w_addr <= A_DUTY_LAST) begin
				if (w_addr[0]) begin
					duty[2'((w_addr - A_DUTY0) >> 1)][11:8] <= w_data[3:0];
				end else begin
					duty[2'((w_addr - A_DUTY0) >> 1)][7:0] <= w_data;
				end
			end
			case (w_addr)
				A_CFG: cfg    <= {5'h00, w_data[2:0]};
				A_BRL: bright[7:0]  <= w_data;
				A_BRH: bright[11:8] <= w_data[3:0];
				A_XL:  cx[7:0]  <= w_data;
				A_XH:  cx[9:8]  <= w_data[1:0];
				A_YL:  cy[7:0]  <= w_data;
				A_YH:  cy[9:8]  <= w_data[1:0];
				A_LL:  lum[7:0]  <= w_data;
				A_LH:  lum[15:8] <= w_data;
				default: ;
			endcase
		end
	end
	assign duty_blue  = duty[0];
	assign duty_green = duty[1];
	assign duty_red   = duty[2];

	// ==========================================================
	// command register
	always_ff @(posedge clk) begin
		if (rst_all) begin
			ctrl <= RST_CTRL;
		end else if (host_w && reg_addr == A_CTRL && state == ST_IDLE &&
			ctrl == RST_CTRL) begin
			ctrl <= {2'h0, reg_wdata[5:1], 1'b0};
		end else if (cmd_clear) begin
			ctrl[cmd_bit] <= 1'b0;
		end
	end

	// ==========================================================
	// sequencer
	always_ff @(posedge clk) begin
		if (rst_all) begin
			state     <= ST_BOOT;
			boot_cnt  <= 8'h00;
			idx       <= 7'h00;
			last      <= 7'h00;
			dir_rd    <= 1'b1;
			boot_load <= 1'b0;
			cmd_bit   <= 3'h0;
			ee_req    <= 1'b0;
		end else begin
			case (state)
				ST_BOOT: begin
					if (boot_cnt == 8'(BOOT_CYCLES - 1)) begin
						state  <= ST_PROBE;
						idx    <= 7'h00;
						dir_rd <= 1'b1;
						ee_req <= 1'b1;
					end else begin
						boot_cnt <= boot_cnt + 8'h01;
					end
				end
				ST_PROBE: begin
					if (ee_done) begin
						if (byte_ok && ee_rdata[B_AUTO]) begin
							state     <= ST_XFER;
							idx       <= 7'h01;
							last      <= 7'(N_ALL - 7'h01);
							boot_load <= 1'b1;
						end else begin
							state  <= ST_IDLE;
							ee_req <= 1'b0;
						end
					end
				end
				ST_IDLE: begin
					// priority: downloads, then uploads, then update
					if (ctrl[B_DLALL] || ctrl[B_DLCAL]) begin
						state   <= ST_XFER;
						idx     <= 7'h00;
						last    <= ctrl[B_DLALL] ? 7'(N_ALL - 7'h01) :
							7'(N_CAL - 7'h01);
						dir_rd  <= 1'b1;
						cmd_bit <= ctrl[B_DLALL] ? 3'(B_DLALL) : 3'(B_DLCAL);
						ee_req  <= 1'b1;
					end else if (ctrl[B_UPALL] || ctrl[B_UPCP]) begin
						state   <= ST_XFER;
						idx     <= ctrl[B_UPALL] ? 7'h00 : CP_FIRST;
						last    <= 7'(N_ALL - 7'h01);
						dir_rd  <= 1'b0;
						cmd_bit <= ctrl[B_UPALL] ? 3'(B_UPALL) : 3'(B_UPCP);
						ee_req  <= 1'b1;
					end else if (ctrl[B_UPD]) begin
						state   <= ST_APPLY;
						cmd_bit <= 3'(B_UPD);
					end
				end
				ST_XFER: begin
					if (xfer_end) begin
						ee_req <= 1'b0;
						// a failed boot load shows nothing
						state  <= (boot_load && !ee_eeprom_no_ack_flag) ? ST_APPLY : ST_IDLE;
						if (ee_eeprom_no_ack_flag) begin
							boot_load <= 1'b0;
						end
					end else if (ee_done) begin
						idx <= idx + 7'h01;
					end
				end
				ST_APPLY: begin
					state     <= ST_IDLE;
					boot_load <= 1'b0;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// set point and error flags
	always_ff @(posedge clk) begin
		if (rst_all) begin
			setpoint <= '0;
			range_f  <= 1'b0;
		end else if (state == ST_APPLY) begin
			if (pt_ok) begin
				setpoint <= '{bright: bright, x: cx, y: cy, lum: lum};
				range_f  <= 1'b0;
			end else begin
				range_f <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			eeprom_no_ack_flag_f <= 1'b0;
		end else if (ee_done && ee_eeprom_no_ack_flag && (xfer_on || state == ST_PROBE)) begin
			eeprom_no_ack_flag_f <= 1'b1;
		end else if (state == ST_IDLE && ctrl[5:2] != 4'h0) begin
			eeprom_no_ack_flag_f <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			bad_acquisition_constant_flag_f <= 1'b0;
		end else if (acq_fault) begin
			bad_acquisition_constant_flag_f <= 1'b1;
		end else if (cal_restart) begin
			bad_acquisition_constant_flag_f <= 1'b0;
		end
	end

	// ==========================================================
	// host read data and pwm outputs
	always_ff @(posedge clk) begin
		if (rst_all) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= local_rd(reg_addr, xfer_on ? 8'h00 : ext_rdata);
		end
	end

	// registered so polarity flips never glitch the led drivers
	always_ff @(posedge clk) begin
		if (rst_all) begin
			led_pwm <= 3'h0;
		end else begin
			led_pwm <= (cfg[B_PWM_ENABLE_BIT] ? pwm_raw : 3'h0) ^
				{3{cfg[B_POL]}};
		end
	end
	assign pwm_enable = cfg[B_PWM_ENABLE_BIT];

	// ==========================================================
	// checks
	property p_soft_reset;
		@(posedge clk) disable iff (!rst_n)
		(reg_wr && !xfer_on && reg_addr == A_CTRL && reg_wdata == 8'h01)
			|-> ##2 (cfg == RST_CFG && duty[0] == RST_DUTY &&
			duty[2] == RST_DUTY && bright == RST_BRIGHT && init_flag);
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset did not restore defaults");

	property p_init_hold;
		@(posedge clk) disable iff (!rst_n)
		$past(rst_all) |-> init_flag [*8];
	endproperty
	a_init_hold: assert property (p_init_hold)
		else $error("initialising flag dropped during boot");

	property p_polarity;
		@(posedge clk) disable iff (rst_all)
		(!cfg[B_PWM_ENABLE_BIT] && cfg[B_POL]) [*2] |-> led_pwm == 3'h7;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("idle active-low outputs not high");

	property p_dlcal;
		@(posedge clk) disable iff (rst_all)
		(state == ST_IDLE && ctrl[B_DLCAL] && !ctrl[B_DLALL]) |=>
			(xfer_on && idx == 7'h00 && last == 7'h32 && dir_rd &&
			map_addr == A_CFG);
	endproperty
	a_dlcal: assert property (p_dlcal)
		else $error("calibration download badly started");

	property p_brightness_high;
		@(posedge clk) disable iff (rst_all)
		(host_w && reg_addr == A_BRH) |=>
			bright[11:8] == $past(reg_wdata[3:0]);
	endproperty
	a_brightness_high: assert property (p_brightness_high)
		else $error("brightness high byte not stored");

	property p_range;
		@(posedge clk) disable iff (rst_all)
		(state == ST_APPLY && !pt_ok) |=> (range_f && $stable(setpoint));
	endproperty
	a_range: assert property (p_range)
		else $error("out of range point not held off");

	property p_upall;
		@(posedge clk) disable iff (rst_all)
		(state == ST_IDLE && ctrl[B_UPALL] && ctrl[5:3] == 3'h2) |=>
			(xfer_on && ee_we && last == 7'h46 && idx == 7'h00);
	endproperty
	a_upall: assert property (p_upall)
		else $error("upload all badly started");

	property p_eeprom_no_ack_flag;
		@(posedge clk) disable iff (rst_all)
		(xfer_on && ee_done && ee_eeprom_no_ack_flag) |=> (eeprom_no_ack_flag_f && state != ST_XFER);
	endproperty
	a_eeprom_no_ack_flag: assert property (p_eeprom_no_ack_flag)
		else $error("no-acknowledge not flagged");

	property p_noauto;
		@(posedge clk) disable iff (rst_all)
		(state == ST_PROBE && ee_done && !ee_rdata[B_AUTO]) |=>
			(state == ST_IDLE && !init_flag && !ee_req);
	endproperty
	a_noauto: assert property (p_noauto)
		else $error("auto load ran with bit clear");

	property p_hold_cmd;
		@(posedge clk) disable iff (rst_all)
		(xfer_on && !boot_load && !xfer_end) |=> ctrl[cmd_bit];
	endproperty
	a_hold_cmd: assert property (p_hold_cmd)
		else $error("command bit cleared mid transfer");

	property p_bad_acquisition_constant_flag;
		@(posedge clk) disable iff (rst_all)
		acq_fault |=> bad_acquisition_constant_flag_f;
	endproperty
	a_bad_acquisition_constant_flag: assert property (p_bad_acquisition_constant_flag)
		else $error("acquisition fault not flagged");

endmodule : ccc_regs

// [sim/ccc_ee_model.sv]
// eeprom partner model answering the byte requests of the sequencer
`timescale 1ns/1ps
module ccc_ee_model (
	input  wire logic       clk,
	input  wire logic       ee_req,
	input  wire logic       ee_we,
	input  wire logic [7:0] ee_addr,
	input  wire logic [7:0] ee_wdata,
	input  wire logic       slow,
	input  wire logic       eeprom_no_ack_flag_mode,
	output logic            ee_done,
	output logic            ee_eeprom_no_ack_flag,
	output logic      [7:0] ee_rdata,
	output int              wr_count,
	output int              rd_count
);
	logic [7:0] mem [0:255];
	logic [2:0] cnt;

	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'h00;
		ee_done = 1'b0;
		ee_eeprom_no_ack_flag = 1'b1;
		ee_rdata = 8'ha5;
		cnt = 3'h0;
		wr_count = 0;
		rd_count = 0;
	end

	// ==========================================================
	// byte service
	// released lines never keep the last value, so they toggle
	always @(posedge clk) begin
		if (ee_done) begin
			ee_done <= 1'b0;
			cnt <= 3'h0;
			ee_eeprom_no_ack_flag <= ~ee_eeprom_no_ack_flag;
			ee_rdata <= ~ee_rdata;
		end else if (ee_req) begin
			cnt <= cnt + 3'h1;
			if (cnt == (slow ? 3'h4 : 3'h0)) begin
				ee_done <= 1'b1;
				ee_eeprom_no_ack_flag <= eeprom_no_ack_flag_mode;
				if (ee_we) begin
					wr_count <= wr_count + 1;
					if (!eeprom_no_ack_flag_mode)
						mem[ee_addr] <= ee_wdata;
				end else begin
					rd_count <= rd_count + 1;
					ee_rdata <= mem[ee_addr];
				end
			end
		end
	end
endmodule : ccc_ee_model

// [sim/tb_ccc_regs.sv]
// self-checking bench for the colour controller command registers
`timescale 1ns/1ps
module tb_ccc_regs;
	import ccc_pkg::*;
	logic          clk, rst_n, reg_wr, reg_rd, ee_req, ee_we, ee_done;
	logic          ee_eeprom_no_ack_flag, ext_we, acq_fault, cal_restart, loop_locked;
	logic          open_loop, pwm_enable, slow, eeprom_no_ack_flag_mode;
	logic [7:0]    reg_addr, reg_wdata, reg_rdata, ee_addr, ee_wdata, d;
	logic [7:0]    ee_rdata, ext_addr, ext_wdata, ext_rdata;
	logic [2:0]    pwm_raw, led_pwm;
	logic [11:0]   duty_blue, duty_green, duty_red;
	ccc_setpoint_t setpoint;
	logic [7:0]    ext_mem [0:255];
	int            miscompares, samples_checked, cycles;
	int            wr_count, rd_count, n0;

	ccc_regs u_ccc_regs (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .ee_req(ee_req), .ee_we(ee_we),
		.ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_done(ee_done),
		.ee_eeprom_no_ack_flag(ee_eeprom_no_ack_flag), .ee_rdata(ee_rdata), .ext_we(ext_we),
		.ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
		.acq_fault(acq_fault), .cal_restart(cal_restart),
		.loop_locked(loop_locked), .open_loop(open_loop),
		.pwm_raw(pwm_raw), .led_pwm(led_pwm), .pwm_enable(pwm_enable),
		.setpoint(setpoint), .duty_blue(duty_blue),
		.duty_green(duty_green), .duty_red(duty_red));

	ccc_ee_model u_ccc_ee_model (.clk(clk), .ee_req(ee_req),
		.ee_we(ee_we), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
		.slow(slow), .eeprom_no_ack_flag_mode(eeprom_no_ack_flag_mode), .ee_done(ee_done),
		.ee_eeprom_no_ack_flag(ee_eeprom_no_ack_flag), .ee_rdata(ee_rdata), .wr_count(wr_count),
		.rd_count(rd_count));

	// ==========================================================
	// table storage beside the block
	assign ext_rdata = ext_mem[ext_addr];
	always @(posedge clk) begin
		if (ext_we)
			ext_mem[ext_addr] <= ext_wdata;
	end

	always #50 clk = ~clk;

	// watchdog on the whole sequence, far above its run time with the slow upload and polling included
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			test_done();
		end
	end

	// ==========================================================
	// host access tasks
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd

	task rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk($sformatf("reg %h", a), 16'(e), 16'(d));
	endtask : rchk

	// bounded wait until the masked bits read zero
	task poll(input logic [7:0] a, input logic [7:0] m);
		d = 8'hff;
		for (int k = 0; k < 3000 && (d & m) != 8'h00; k++)
			rd(a);
		chk($sformatf("poll %h", a), 16'h0000, 16'(d & m));
	endtask : poll

	task do_reset();
		rst_n = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		rchk(A_STAT, 8'h03);
		poll(A_STAT, 8'h01);
	endtask : do_reset

	task sp(input logic [9:0] x, input logic [9:0] y);
		wr(A_XL, x[7:0]);
		wr(A_XH, {6'h00, x[9:8]});
		wr(A_YL, y[7:0]);
		wr(A_YH, {6'h00, y[9:8]});
		wr(A_CTRL, 8'h02);
		poll(A_CTRL, 8'hff);
	endtask : sp

	task test_done();
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// ==========================================================
	// main sequence
	initial begin
		{clk, rst_n, reg_wr, reg_rd, acq_fault, cal_restart} = 6'h00;
		{loop_locked, open_loop, slow, eeprom_no_ack_flag_mode} = 4'h0;
		{reg_addr, reg_wdata, pwm_raw} = 19'h0_0000;
		{miscompares, samples_checked, cycles} = 96'h0;
		for (int i = 0; i < 256; i++)
			ext_mem[i] = 8'(i);
		do_reset();
		rchk(A_BRL, 8'h79);
		rchk(A_BRH, 8'h0e);
		rchk(A_CFG, 8'h00);
		rchk(A_ERR, 8'h00);
		wr(A_STAT, 8'hff);
		rchk(A_STAT, 8'h02);
		open_loop = 1'b1;
		rchk(A_STAT, 8'h04);
		open_loop = 1'b0;
		wr(8'h05, 8'h5a);
		rchk(8'h05, 8'h5a);
		wr(A_BRH, 8'h0e);
		wr(A_BRL, 8'h10);
		rchk(A_BRL, 8'h10);
		rchk(A_BRH, 8'h0e);
		wr(A_LL, 8'he8);
		wr(A_LH, 8'h03);
		sp(10'h139, 10'h149);
		rchk(A_XH, 8'h01);
		chk("sp x", 16'h0139, 16'(setpoint.x));
		chk("sp br", 16'h0e10, 16'(setpoint.bright));
		chk("sp lum", 16'h03e8, setpoint.lum);
		sp(10'h000, 10'h149);
		rchk(A_ERR, 8'h01);
		chk("sp kept", 16'h0139, 16'(setpoint.x));
		sp(10'h139, 10'h149);
		rchk(A_ERR, 8'h00);
		pwm_raw = 3'h5;
		for (int i = 0; i < 4; i++) begin
			wr(A_CFG, 8'(i));
			repeat (2) @(negedge clk);
			chk("led", 16'((i[0] ? 3'h5 : 3'h0) ^ {3{i[1]}}),
				16'(led_pwm));
			chk("pwm en", 16'(i & 1), 16'(pwm_enable));
			rchk(A_ERR, 8'(i & 1) << 1);
		end
		loop_locked = 1'b1;
		rchk(A_ERR, 8'h00);
		acq_fault = 1'b1;
		@(negedge clk);
		acq_fault = 1'b0;
		rchk(A_ERR, 8'h80);
		cal_restart = 1'b1;
		@(negedge clk);
		cal_restart = 1'b0;
		rchk(A_ERR, 8'h00);
		for (int a = 36; a < 42; a++)
			wr(8'(a), 8'h05);
		chk("duty b", 16'h0505, 16'(duty_blue));
		chk("duty g", 16'h0505, 16'(duty_green));
		chk("duty r", 16'h0505, 16'(duty_red));
		wr(A_CFG, 8'h05);
		n0 = wr_count;
		slow = 1'b1;
		wr(A_CTRL, 8'h10);
		rchk(A_CTRL, 8'h10);
		poll(A_CTRL, 8'hff);
		slow = 1'b0;
		chk("up all", 16'h0047, 16'(wr_count - n0));
		rchk(A_ERR, 8'h00);
		chk("ee cfg", 16'h0005, 16'(u_ccc_ee_model.mem[0]));
		chk("ee br", 16'h0e10, {u_ccc_ee_model.mem[64],
			u_ccc_ee_model.mem[63]});
		n0 = wr_count;
		wr(A_CTRL, 8'h04);
		poll(A_CTRL, 8'hff);
		chk("up cp", 16'h0008, 16'(wr_count - n0));
		eeprom_no_ack_flag_mode = 1'b1;
		wr(A_CTRL, 8'h04);
		poll(A_CTRL, 8'hff);
		rchk(A_ERR, 8'h20);
		eeprom_no_ack_flag_mode = 1'b0;
		n0 = rd_count;
		wr(A_CTRL, 8'h01);
		repeat (3) @(negedge clk);
		rchk(A_STAT, 8'h03);
		poll(A_STAT, 8'h01);
		chk("auto rd", 16'h0047, 16'(rd_count - n0));
		rchk(A_CFG, 8'h05);
		chk("auto br", 16'h0e10, 16'(setpoint.bright));
		chk("auto led", 16'h0005, 16'(led_pwm));
		chk("auto en", 16'h0001, 16'(pwm_enable));
		chk("duty rst", 16'h0000, 16'(duty_red));
		for (int a = 36; a < 42; a++)
			rchk(8'(a), 8'h00);
		n0 = rd_count;
		wr(A_CTRL, 8'h20);
		poll(A_CTRL, 8'hff);
		chk("dl cal", 16'h0033, 16'(rd_count - n0));
		n0 = rd_count;
		wr(A_CTRL, 8'h08);
		poll(A_CTRL, 8'hff);
		chk("dl all", 16'h0047, 16'(rd_count - n0));
		wr(A_CFG, 8'h00);
		wr(A_CTRL, 8'h10);
		poll(A_CTRL, 8'hff);
		n0 = rd_count;
		do_reset();
		chk("no auto", 16'h0001, 16'(rd_count - n0));
		rchk(A_CFG, 8'h00);
		chk("rst en", 16'h0000, 16'(pwm_enable));
		test_done();
	end
endmodule : tb_ccc_regs
